// File: rtl/cpt_pkg.sv
// Shared constants and types of the process data transmit scheduler
package cpt_pkg;

  // ---------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------
  localparam int NUM_PDO = 4;
  localparam int FIFO_DEPTH = 4;
  localparam logic [6:0] MAX_MAP_BITS = 7'h40;

  // ---------------------------------------------------------------------
  // Transmission type codes
  // ---------------------------------------------------------------------
  localparam logic [7:0] TT_ACYCLIC = 8'h00;
  localparam logic [7:0] SYNC_RATE_MIN = 8'h01;
  localparam logic [7:0] SYNC_RATE_MAX = 8'hf0;
  localparam logic [7:0] TT_EVT_MFR = 8'hfe;
  localparam logic [7:0] TT_EVT_PROFILE = 8'hff;

  // ---------------------------------------------------------------------
  // Inhibit time, in 0.1 ms units
  // ---------------------------------------------------------------------
  localparam logic [15:0] INHIB_MIN = 16'h0014;
  localparam logic [15:0] INHIB_MAX = 16'h4e20;
  localparam logic [15:0] INHIB_RESET = 16'h0014;
  localparam int INHIB_UNIT_NS = 100000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_CYCLES = (INHIB_UNIT_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CFG_BASE = 8'h10;
  localparam logic [7:0] ADDR_INHIB_BASE = 8'h20;
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_EN_BIT = 3;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_MAP_LSB = 8;
  localparam int STAT_FULL_BIT = 8;
  localparam logic [7:0] CFG_TYPE_RESET = 8'hff;
  localparam logic [6:0] CFG_MAP_RESET = 7'h40;

  // ---------------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    RATE_1000K = 3'h0,
    RATE_800K = 3'h1,
    RATE_500K = 3'h2,
    RATE_250K = 3'h3,
    RATE_125K = 3'h4,
    RATE_50K = 3'h5,
    RATE_20K = 3'h6,
    RATE_10K = 3'h7
  } cpt_rate_t;

  typedef enum logic [1:0] {
    MODE_ACYC = 2'b00,
    MODE_CYC = 2'b01,
    MODE_EVENT = 2'b10,
    MODE_OFF = 2'b11
  } cpt_mode_t;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pdoIdx;
    logic [3:0] byteLen;
  } cpt_tx_t;

  typedef struct packed {
    logic [7:0] txType;
    logic [6:0] mapBits;
    logic [15:0] inhibit;
  } cpt_cfg_t;

  typedef struct packed {
    logic [7:0] syncCnt;
    logic [15:0] inhibLeft;
    logic pend;
    logic armed;
    logic due;
  } cpt_pdo_t;

endpackage

// File: rtl/cpt_scheduler.sv
// Transmit FIFO and process data transmit scheduler with APB registers
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns

module cpt_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("FIFO depth must be a power of two, at least two");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
  } cpt_fifo_st_t;

  cpt_fifo_st_t st_ff;
  cpt_fifo_st_t nxt_st;
  logic push;
  logic pop;

  assign inReady = (st_ff.count != CW'(DEPTH));
  assign outValid = (st_ff.count != '0);
  assign outData = st_ff.mem[st_ff.rptr];

  always_comb begin
    nxt_st = st_ff;
    push = inValid && inReady;
    pop = outValid && outReady;
    if (push) begin
      nxt_st.mem[st_ff.wptr] = inData;
      nxt_st.wptr = st_ff.wptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rptr = st_ff.rptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

module cpt_scheduler #(
  parameter int NUM = cpt_pkg::NUM_PDO,
  parameter int DEPTH = cpt_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic syncPulse,
  input wire logic [NUM-1:0] dataEvent,
  output logic txValid,
  input wire logic txReady,
  output cpt_pkg::cpt_tx_t txEntry,
  output cpt_pkg::cpt_rate_t bitRate
);
  import cpt_pkg::*;

  generate
    if (NUM < 1 || NUM > 4) begin : g_chk
      $error("Between one and four objects are supported");
    end
  endgenerate

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    cpt_cfg_t [NUM-1:0] cfg;
    cpt_pdo_t [NUM-1:0] pdo;
    logic [11:0] tickCnt;
    cpt_rate_t rate;
    logic enable;
    logic [31:0] rdata;
  } cpt_state_t;

  cpt_state_t st_ff;
  cpt_state_t nxt_st;
  logic fifoReady;
  logic pushValid;
  cpt_tx_t pushData;
  logic tick;
  logic found;
  logic [1:0] sel;
  logic [1:0] idx;
  logic idxOk;
  logic isCfg;
  logic isInhib;
  logic mapped;
  logic wrBad;
  logic access;
  cpt_mode_t mode;
  cpt_pdo_t p;

  function automatic cpt_mode_t modeOf(input logic [7:0] t);
    if (t == TT_ACYCLIC) begin
      modeOf = MODE_ACYC;
    end else if (t >= SYNC_RATE_MIN && t <= SYNC_RATE_MAX) begin
      modeOf = MODE_CYC;
    end else if (t == TT_EVT_MFR || t == TT_EVT_PROFILE) begin
      modeOf = MODE_EVENT;
    end else begin
      modeOf = MODE_OFF;
    end
  endfunction

  assign access = psel && penable;
  assign pready = 1'b1;
  assign prdata = st_ff.rdata;
  assign bitRate = st_ff.rate;
  assign pslverr = access && (!mapped || (pwrite && wrBad));

  // ---------------------------------------------------------------------
  // Address decode and write check
  // ---------------------------------------------------------------------
  always_comb begin
    idx = paddr[3:2];
    idxOk = (32'(idx) < NUM) && (paddr[1:0] == 2'b00);
    isCfg = idxOk && (paddr[7:4] == ADDR_CFG_BASE[7:4]);
    isInhib = idxOk && (paddr[7:4] == ADDR_INHIB_BASE[7:4]);
    mapped = isCfg || isInhib || paddr == ADDR_CTRL || paddr == ADDR_STATUS;
    wrBad = 1'b0;
    if (isCfg) begin
      // Reserved type codes and maps over 64 bits are refused
      wrBad = (modeOf(pwdata[CFG_TYPE_LSB +: 8]) == MODE_OFF) ||
              (pwdata[CFG_MAP_LSB +: 7] > MAX_MAP_BITS);
    end else if (isInhib) begin
      wrBad = (pwdata[15:0] < INHIB_MIN) ||
              (pwdata[15:0] > INHIB_MAX);
    end else if (paddr == ADDR_STATUS) begin
      wrBad = 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    pushValid = 1'b0;
    pushData = '0;
    found = 1'b0;
    sel = '0;
    mode = MODE_OFF;
    p = '0;

    // 0.1 ms time base for the inhibit counters
    tick = (st_ff.tickCnt == 12'(TICK_CYCLES - 1));
    nxt_st.tickCnt = tick ? '0 : st_ff.tickCnt + 1'b1;

    // Read data is captured in the setup phase
    if (psel && !penable) begin
      nxt_st.rdata = '0;
      if (paddr == ADDR_CTRL) begin
        nxt_st.rdata[CTRL_RATE_LSB +: 3] = st_ff.rate;
        nxt_st.rdata[CTRL_EN_BIT] = st_ff.enable;
      end else if (paddr == ADDR_STATUS) begin
        for (int i = 0; i < NUM; i++) begin
          nxt_st.rdata[i] = st_ff.pdo[i].pend || st_ff.pdo[i].armed ||
                            st_ff.pdo[i].due;
        end
        nxt_st.rdata[STAT_FULL_BIT] = !fifoReady;
      end else if (isCfg) begin
        nxt_st.rdata[CFG_TYPE_LSB +: 8] = st_ff.cfg[idx].txType;
        nxt_st.rdata[CFG_MAP_LSB +: 7] = st_ff.cfg[idx].mapBits;
      end else if (isInhib) begin
        nxt_st.rdata[15:0] = st_ff.cfg[idx].inhibit;
      end
    end

    // Lowest index that is due wins the FIFO slot
    for (int i = NUM - 1; i >= 0; i--) begin
      if (st_ff.pdo[i].due) begin
        found = 1'b1;
        sel = 2'(i);
      end
    end
    if (found && st_ff.enable) begin
      pushValid = 1'b1;
      pushData.pdoIdx = 8'(sel);
      pushData.byteLen = 4'((st_ff.cfg[sel].mapBits + 7'h07) >> 3);
    end

    for (int i = 0; i < NUM; i++) begin
      mode = modeOf(st_ff.cfg[i].txType);
      p = st_ff.pdo[i];
      if (tick && p.inhibLeft != '0) begin
        p.inhibLeft = p.inhibLeft - 1'b1;
      end
      // A taken send clears first, so a new event below still lands
      if (pushValid && fifoReady && sel == 2'(i)) begin
        p.due = 1'b0;
        p.pend = 1'b0;
        // Inhibit only guards event types
        p.inhibLeft = (mode == MODE_EVENT) ?
                      st_ff.cfg[i].inhibit : '0;
      end
      if (st_ff.enable) begin
        case (mode)
          MODE_ACYC: begin
            if (syncPulse && p.armed) begin
              p.due = 1'b1;
              p.armed = 1'b0;
            end
            if (dataEvent[i]) begin
              p.armed = 1'b1;
            end
          end
          MODE_CYC: begin
            if (syncPulse) begin
              if (p.syncCnt + 8'h01 >= st_ff.cfg[i].txType) begin
                p.due = 1'b1;
                p.syncCnt = '0;
              end else begin
                p.syncCnt = p.syncCnt + 8'h01;
              end
            end
          end
          MODE_EVENT: begin
            // Codes 254 and 255 both fire on the data event input
            if (dataEvent[i]) begin
              p.pend = 1'b1;
            end
            // No event timer: only data events cause sends
            p.due = p.pend && (p.inhibLeft == '0);
          end
          default: begin
            p = '0;
          end
        endcase
      end
      nxt_st.pdo[i] = p;
    end

    // Register writes take effect in the access phase
    if (access && pwrite && mapped && !wrBad) begin
      if (paddr == ADDR_CTRL) begin
        nxt_st.rate = cpt_rate_t'(pwdata[CTRL_RATE_LSB +: 3]);
        nxt_st.enable = pwdata[CTRL_EN_BIT];
      end else if (isCfg) begin
        nxt_st.cfg[idx].txType = pwdata[CFG_TYPE_LSB +: 8];
        nxt_st.cfg[idx].mapBits = pwdata[CFG_MAP_LSB +: 7];
        nxt_st.pdo[idx] = '0;
      end else if (isInhib) begin
        nxt_st.cfg[idx].inhibit = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
      for (int i = 0; i < NUM; i++) begin
        st_ff.cfg[i].txType <= CFG_TYPE_RESET;
        st_ff.cfg[i].mapBits <= CFG_MAP_RESET;
        st_ff.cfg[i].inhibit <= INHIB_RESET;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------
  // Transmit queue toward the CAN controller
  // ---------------------------------------------------------------------
  cpt_fifo #(
    .WIDTH($bits(cpt_tx_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .inValid(pushValid),
    .inReady(fifoReady),
    .inData(pushData),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txEntry)
  );
endmodule

// File: testbench/cpt_scheduler_props.sv
// Checker of the scheduler top-level ports
`timescale 1ns/1ns
module cpt_scheduler_props
  import cpt_pkg::*;
#(
  parameter int NUM = NUM_PDO
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic syncPulse,
  input wire logic [NUM-1:0] dataEvent,
  input wire logic txValid,
  input wire logic txReady,
  input wire cpt_tx_t txEntry,
  input wire cpt_rate_t bitRate
);
  logic wr;
  logic cfgA;
  logic inhA;
  assign wr = psel && penable && pwrite;
  assign cfgA = paddr >= ADDR_CFG_BASE && paddr < ADDR_CFG_BASE + 4 * NUM;
  assign inhA = paddr >= ADDR_INHIB_BASE &&
                paddr < ADDR_INHIB_BASE + 4 * NUM && paddr[1:0] == 2'b00;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  len_max_a: assert property (txValid |-> txEntry.byteLen <= 4'h8)
    else $error("entry longer than eight bytes");
  idx_range_a: assert property (txValid |-> txEntry.pdoIdx < NUM)
    else $error("entry index out of range");
  entry_hold_a: assert property (txValid && !txReady |=>
    txValid && $stable(txEntry)) else $error("entry lost before pop");
  map_refuse_a: assert property (wr && cfgA &&
    pwdata[14:8] > MAX_MAP_BITS |-> pslverr) else $error("map accepted");
  type_refuse_a: assert property (wr && cfgA &&
    pwdata[7:0] > SYNC_RATE_MAX && pwdata[7:0] < TT_EVT_MFR |-> pslverr)
    else $error("bad type accepted");
  inhib_refuse_a: assert property (wr && inhA && (pwdata[15:0] <
    INHIB_MIN || pwdata[15:0] > INHIB_MAX) |-> pslverr)
    else $error("bad inhibit accepted");
  inhib_take_a: assert property (wr && inhA &&
    pwdata[15:0] >= INHIB_MIN && pwdata[15:0] <= INHIB_MAX |-> !pslverr)
    else $error("good inhibit refused");
  rate_hold_a: assert property ($changed(bitRate) |->
    $past(wr && paddr == ADDR_CTRL)) else $error("rate changed alone");
  rate_follow_a: assert property (wr && paddr == ADDR_CTRL |=>
    bitRate == $past(pwdata[2:0])) else $error("rate not taken");
  stall_c: cover property (txValid && !txReady);
  refuse_c: cover property (wr && cfgA && pslverr);
  sync_c: cover property (syncPulse ##[1:3] txValid);
endmodule

bind cpt_scheduler cpt_scheduler_props #(.NUM(NUM)) i_cpt_scheduler_props (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .syncPulse(syncPulse),
  .dataEvent(dataEvent), .txValid(txValid), .txReady(txReady),
  .txEntry(txEntry), .bitRate(bitRate));

// File: testbench/cpt_master_model.sv
// Network master model: SYNC source and frame consumer
`timescale 1ns/1ns
module cpt_master_model
  import cpt_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic txValid,
  input wire cpt_tx_t txEntry,
  input wire logic stall,
  input wire logic syncReq,
  output logic txReady,
  output logic syncPulse,
  output logic [15:0] popCount,
  output cpt_tx_t lastEntry
);
  // Stalls back-pressure the queue like a busy bus
  assign txReady = !stall;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      syncPulse <= 1'b0;
      popCount <= 16'h0000;
      lastEntry <= '0;
    end else begin
      syncPulse <= syncReq;
      if (txValid && txReady) begin
        popCount <= popCount + 16'h0001;
        lastEntry <= txEntry;
      end
    end
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench of the transmit scheduler
`timescale 1ns/1ns
module tb;
  import cpt_pkg::*;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, syncPulse, txValid, txReady;
  logic [3:0] dataEvent = 4'h0;
  logic stall = 0, syncReq = 0;
  logic [15:0] popCount;
  cpt_tx_t txEntry, lastEntry;
  cpt_rate_t bitRate;
  int err_count = 0, compares = 0;
  logic [7:0] ba [7] = '{8'h10, 8'h10, 8'h10, 8'h20, 8'h20, 8'h04, 8'h80};
  logic [31:0] bd [7] = '{32'hf1, 32'hfd, 32'h41ff, 32'h13, 32'h4e21,
                          32'h0, 32'h0};
  always #25 clk = ~clk;
  cpt_scheduler i_cpt_scheduler (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .syncPulse(syncPulse), .dataEvent(dataEvent), .txValid(txValid),
    .txReady(txReady), .txEntry(txEntry), .bitRate(bitRate));
  cpt_master_model i_cpt_master_model (.clk(clk), .reset(reset),
    .txValid(txValid), .txEntry(txEntry), .stall(stall),
    .syncReq(syncReq), .txReady(txReady), .syncPulse(syncPulse),
    .popCount(popCount), .lastEntry(lastEntry));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(logic w, logic [7:0] a, logic [31:0] d, logic e,
           output logic [31:0] r);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", {31'h0, e}, {31'h0, pslverr});
    psel <= 0;
    penable <= 0;
  endtask
  task wr(logic [7:0] a, logic [31:0] d, logic e);
    logic [31:0] r;
    apb(1, a, d, e, r);
  endtask
  task rd(logic [7:0] a, logic [31:0] x, logic e);
    logic [31:0] r;
    apb(0, a, 32'h0, e, r);
    chk("prdata", x, r);
  endtask
  task ev(logic [3:0] m);
    @(posedge clk);
    dataEvent <= m;
    @(posedge clk);
    dataEvent <= 4'h0;
  endtask
  task sync;
    @(posedge clk);
    syncReq <= 1;
    @(posedge clk);
    syncReq <= 0;
  endtask
  task pop(logic [11:0] x, int maxc);
    logic [15:0] b;
    int i;
    b = popCount;
    i = 0;
    while (popCount === b && i < maxc) begin
      @(posedge clk);
      i++;
    end
    chk("popCount", b + 16'h1, popCount);
    chk("txEntry", x, lastEntry);
  endtask
  task quiet(int n);
    logic [15:0] b;
    b = popCount;
    repeat (n) @(posedge clk);
    chk("idle", b, popCount);
  endtask
  task close_out;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #3000000;
    err_count++;
    close_out;
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset <= 0;
    rd(ADDR_CTRL, 32'h0, 0);
    rd(ADDR_CFG_BASE, {17'h0, CFG_MAP_RESET, CFG_TYPE_RESET}, 0);
    rd(ADDR_INHIB_BASE, {16'h0, INHIB_RESET}, 0);
    for (int i = 0; i < 7; i++) wr(ba[i], bd[i], 1);
    rd(8'h80, 32'h0, 1);
    rd(ADDR_CFG_BASE, 32'h40ff, 0);
    wr(ADDR_INHIB_BASE + 8'h04, 32'h4e20, 0);
    rd(ADDR_INHIB_BASE + 8'h04, 32'h4e20, 0);
    wr(ADDR_INHIB_BASE + 8'h04, 32'h14, 0);
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_CTRL, r, 0);
      // The register updates at the access edge; look once it has settled
      @(negedge clk);
      chk("bitRate", r, {29'h0, bitRate});
    end
    wr(ADDR_CFG_BASE + 8'h04, 32'h0cfe, 0);
    wr(ADDR_CFG_BASE + 8'h08, 32'h0100, 0);
    wr(ADDR_CTRL, 32'h8, 0);
    ev(4'h1);
    pop({8'h0, 4'h8}, 10);
    ev(4'h2);
    pop({8'h1, 4'h2}, 10);
    ev(4'h4);
    quiet(20);
    sync;
    pop({8'h2, 4'h1}, 10);
    wr(ADDR_CFG_BASE + 8'h0c, 32'h0003, 0);
    repeat (2) begin
      sync;
      sync;
      quiet(10);
      sync;
      pop({8'h3, 4'h0}, 10);
    end
    ev(4'h1);
    ev(4'h1);
    quiet(37000);
    pop({8'h0, 4'h8}, 5000);
    quiet(100);
    wr(ADDR_CFG_BASE + 8'h0c, 32'h0001, 0);
    stall <= 1;
    repeat (5) sync;
    quiet(5);
    rd(ADDR_STATUS, 32'h108, 0);
    stall <= 0;
    repeat (5) pop({8'h3, 4'h0}, 20);
    quiet(20);
    rd(ADDR_STATUS, 32'h0, 0);
    close_out;
  end
endmodule
